// file: rtl/cdr_cfg.svh
// Purpose: constants of the lock controller and deserializer
// Assumes: one 100 MHz clock, mclk_in
// Notes:   included by its bare name
`ifndef CDR_CFG_SVH
`define CDR_CFG_SVH

// Word widths
`define WORD_W_WIDE   4'hA
`define WORD_W_NARROW 4'h8
`define WORD_MAX      10

// Reset values
`define LOCK_FLAG_RST 1'h0
`define WORD_RST      10'h000
`define BIT_CNT_RST   4'h0

`endif

// file: rtl/cdr_pkg.sv
// Purpose: shared types of the lock controller and deserializer
// Assumes: nothing
// Notes:   one-hot state codes
package cdr_pkg;

	// Clock recovery unit state
	typedef enum logic [1:0] {
		REFERENCE_LOCKED_STATE = 2'h1,
		DATA_TRACKING_STATE    = 2'h2
	} cdr_state_t;

endpackage

// file: rtl/sync2.sv
// Purpose: two flip-flop synchroniser for a level
// Assumes: synchronous active-high reset
// Notes:   first stage is read only by the second
`timescale 1ns/1ps
module sync2 #(
	parameter logic RST_VAL = 1'h0
) (
	input  wire logic mclk_in, // Clock
	input  wire logic rst_in,  // Synchronous reset
	input  wire logic d_in,    // Asynchronous level
	output logic      q_out    // Synchronised level
);

	logic s1_q;
	logic s1_d;
	logic s2_d;

	// Next values
	always_comb begin
		s1_d = d_in;
		s2_d = s1_q;
	end

	// Registers
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			s1_q  <= RST_VAL;
			q_out <= RST_VAL;
		end else begin
			s1_q  <= s1_d;
			q_out <= s2_d;
		end
	end

endmodule

// file: rtl/deser.sv
// Purpose: serial to parallel conversion, first bit into bit 0
// Assumes: one serial bit per clock with a bit strobe
// Notes:   8 or 10 bit words chosen by a level
`timescale 1ns/1ps
`include "cdr_cfg.svh"
module deser #(
	parameter int WORD_MAX = `WORD_MAX
) (
	input  wire logic                mclk_in,  // Clock
	input  wire logic                rst_in,   // Synchronous reset
	input  wire logic                bit_in,   // Serial bit
	input  wire logic                bit_vld_in, // Serial bit strobe
	input  wire logic                wide_in,  // 1: 10-bit words
	output logic [WORD_MAX-1:0]      word_out, // Parallel word
	output logic                     word_vld_out // Word strobe
);

	logic [WORD_MAX-1:0] shift_q;
	logic [WORD_MAX-1:0] shift_d;
	logic [3:0]          cnt_q;
	logic [3:0]          cnt_d;
	logic [WORD_MAX-1:0] word_d;
	logic                vld_d;
	logic [3:0]          last;

	// Bits enter at the top and move down, so first lands in bit 0
	always_comb begin
		last    = wide_in ? `WORD_W_WIDE : `WORD_W_NARROW;
		shift_d = shift_q;
		cnt_d   = cnt_q;
		word_d  = word_out;
		vld_d   = 1'h0;
		if (bit_vld_in) begin
			shift_d = {bit_in, shift_q[WORD_MAX-1:1]};
			if (cnt_q == last - 4'h1) begin
				cnt_d = `BIT_CNT_RST;
				vld_d = 1'h1;
				// Narrow words were filled from the top; realign
				if (wide_in)
					word_d = shift_d;
				else
					word_d = {2'h0, shift_d[WORD_MAX-1:2]};
			end else begin
				cnt_d = cnt_q + 4'h1;
			end
		end
	end

	// Registers
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			shift_q      <= `WORD_RST;
			cnt_q        <= `BIT_CNT_RST;
			word_out     <= `WORD_RST;
			word_vld_out <= 1'h0;
		end else begin
			shift_q      <= shift_d;
			cnt_q        <= cnt_d;
			word_out     <= word_d;
			word_vld_out <= vld_d;
		end
	end

endmodule

// file: rtl/cdr_lock_ctrl_deserializer.sv
// Purpose: clock recovery lock controller with deserializer
// Assumes: analog detectors deliver levels from outside the clock domain
// Notes:   the two-edge fast clock is modelled as a bit strobe
//
// Operation
// - after reset the unit sits in the reference-locked state
// - reference-locked disables the phase detector; data ignored
// - data-tracking enables the phase detector to follow the data
// - automatic entry to tracking needs frequency inside ppm window
// - PIPE mode also needs signal present; otherwise detection ignored
// - automatic mode falls back when frequency leaves the window
// - PIPE mode also falls back when signal is absent
// - automatic lock flag rises on entry, falls on fallback
// - manual mode state follows the two force inputs, else the automatic rules
// - manual lock flag high in tracking, low in reference-locked
// - without manual controls enabled the controller runs automatic
// - detection only with 8b10b enabled, else signal present held high
// - signal present asserted when input level exceeds threshold
// - words are 8 or 10 bits by configuration
// - first received bit lands in bit 0
// - deserializer runs on fast recovered clock, both edges
// - slow recovered clock drives the downstream PCS
// - reference taken from one of two adjacent PLLs by configuration
`timescale 1ns/1ps
`include "cdr_cfg.svh"
module cdr_lock_ctrl_deserializer #(
	parameter int WORD_MAX = `WORD_MAX
) (
	input  wire logic                mclk_in,       // Clock
	input  wire logic                rst_in,        // Synchronous reset
	input  wire logic                manual_en_in,  // Manual ports enabled
	input  wire logic                pipe_mode_in,  // PCIe PIPE mode
	input  wire logic                enc_en_in,     // 8b10b enabled
	input  wire logic                level_above_in, // Analog detector
	input  wire logic                ppm_ok_in,     // Freq within window
	input  wire logic                force_ref_lock_in,  // Manual ref
	input  wire logic                force_data_lock_in, // Manual data
	input  wire logic                pll_sel_in,    // Reference PLL select
	input  wire logic                pll0_clk_in,   // PLL 0 reference
	input  wire logic                pll1_clk_in,   // PLL 1 reference
	input  wire logic                fast_clk_in,   // Fast recovered clk
	input  wire logic                slow_clk_in,   // Slow recovered clk
	input  wire logic                ser_bit_in,    // Serial bit
	input  wire logic                ser_vld_in,    // Serial bit strobe
	input  wire logic                wide_in,       // 1: 10-bit words
	output logic                     signal_present_out, // Signal valid
	output logic                     freq_lock_flag_out, // Tracking
	output logic                     phase_det_en_out,   // Phase detector
	output logic                     ref_clk_out,        // Chosen ref
	output logic                     deser_clk_out,      // Deser clock
	output logic                     pcs_clk_out,        // PCS clock
	output logic [WORD_MAX-1:0]      word_out,           // Parallel word
	output logic                     word_vld_out        // Word strobe
);

	////////////////////////////////////////////////////////////////////
	// Input synchronisers

	logic level_s;
	logic ppm_s;
	logic fref_s;
	logic fdata_s;

	// Analog and fabric levels cross into mclk domain
	sync2 #(.RST_VAL(1'h0)) u_lvl (
		.mclk_in (mclk_in),
		.rst_in  (rst_in),
		.d_in    (level_above_in),
		.q_out   (level_s)
	);
	sync2 #(.RST_VAL(1'h0)) u_ppm (
		.mclk_in (mclk_in),
		.rst_in  (rst_in),
		.d_in    (ppm_ok_in),
		.q_out   (ppm_s)
	);
	sync2 #(.RST_VAL(1'h0)) u_fref (
		.mclk_in (mclk_in),
		.rst_in  (rst_in),
		.d_in    (force_ref_lock_in),
		.q_out   (fref_s)
	);
	sync2 #(.RST_VAL(1'h0)) u_fdat (
		.mclk_in (mclk_in),
		.rst_in  (rst_in),
		.d_in    (force_data_lock_in),
		.q_out   (fdata_s)
	);

	////////////////////////////////////////////////////////////////////
	// Signal detection

	logic sig_d;

	// Bypassed high when the 8b10b path is off
	always_comb begin
		if (enc_en_in)
			sig_d = level_s;
		else
			sig_d = 1'h1;
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in)
			signal_present_out <= 1'h0;
		else
			signal_present_out <= sig_d;
	end

	////////////////////////////////////////////////////////////////////
	// Lock controller

	cdr_pkg::cdr_state_t state_q;
	cdr_pkg::cdr_state_t state_d;
	logic                sig_gate;
	logic                go_track;
	logic                go_ref;
	logic                flag_d;

	// Signal presence only gates transitions in PIPE mode
	always_comb begin
		sig_gate = pipe_mode_in ? signal_present_out : 1'h1;
		go_track = ppm_s && sig_gate;
		go_ref   = !ppm_s || !sig_gate;
		state_d  = state_q;
		case (state_q)
			cdr_pkg::REFERENCE_LOCKED_STATE: begin
				if (manual_en_in && fref_s)
					state_d = cdr_pkg::REFERENCE_LOCKED_STATE;
				else if (manual_en_in && fdata_s)
					state_d = cdr_pkg::DATA_TRACKING_STATE;
				else if (go_track)
					state_d = cdr_pkg::DATA_TRACKING_STATE;
			end
			cdr_pkg::DATA_TRACKING_STATE: begin
				if (manual_en_in && fref_s)
					state_d = cdr_pkg::REFERENCE_LOCKED_STATE;
				else if (manual_en_in && fdata_s)
					state_d = cdr_pkg::DATA_TRACKING_STATE;
				else if (go_ref)
					state_d = cdr_pkg::REFERENCE_LOCKED_STATE;
			end
			default: state_d = cdr_pkg::REFERENCE_LOCKED_STATE;
		endcase
		// Flag decoded from the next state, so it matches state_q in both modes
		flag_d = (state_d == cdr_pkg::DATA_TRACKING_STATE);
	end

	// Reset always returns to reference-locked
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			state_q            <= cdr_pkg::REFERENCE_LOCKED_STATE;
			freq_lock_flag_out <= `LOCK_FLAG_RST;
		end else begin
			state_q            <= state_d;
			freq_lock_flag_out <= flag_d;
		end
	end

	// Phase detector on only while tracking; data otherwise ignored
	assign phase_det_en_out =
		(state_q == cdr_pkg::DATA_TRACKING_STATE);

	////////////////////////////////////////////////////////////////////
	// Clock routing
	// Clocks are passed through as a mux; no logic here runs on them

	assign ref_clk_out   = pll_sel_in ? pll1_clk_in : pll0_clk_in;
	assign deser_clk_out = fast_clk_in;
	assign pcs_clk_out   = slow_clk_in;

	////////////////////////////////////////////////////////////////////
	// Deserializer

	logic bit_vld;

	// Bits only count as recovered while tracking
	assign bit_vld = ser_vld_in && phase_det_en_out;

	deser #(.WORD_MAX(WORD_MAX)) u_deser (
		.mclk_in      (mclk_in),
		.rst_in       (rst_in),
		.bit_in       (ser_bit_in),
		.bit_vld_in   (bit_vld),
		.wide_in      (wide_in),
		.word_out     (word_out),
		.word_vld_out (word_vld_out)
	);

endmodule

// file: testbench/cdr_lock_checker.sv
// Purpose: port assertions of the lock controller
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to the top module below
`timescale 1ns/1ps
module cdr_lock_checker (
	input wire logic	mclk_in,            // Clock
	input wire logic	rst_in,             // Reset
	input wire logic	manual_en_in,       // Manual
	input wire logic	pipe_mode_in,       // PIPE
	input wire logic	enc_en_in,          // 8b10b
	input wire logic	ppm_ok_in,          // Window
	input wire logic	force_ref_lock_in,  // Ref force
	input wire logic	force_data_lock_in, // Data force
	input wire logic	pll_sel_in,         // PLL select
	input wire logic	pll0_clk_in,        // PLL 0
	input wire logic	pll1_clk_in,        // PLL 1
	input wire logic	signal_present_out, // Signal
	input wire logic	freq_lock_flag_out, // Lock flag
	input wire logic	phase_det_en_out,   // Phase det
	input wire logic	ref_clk_out,        // Ref clock
	input wire logic	word_vld_out        // Word strobe
);
	default clocking @(posedge mclk_in);
	endclocking
	default disable iff (rst_in);
	// Aliases; sync stages give three edges of input latency
	wire lk = freq_lock_flag_out;
	wire au = !manual_en_in;
	wire fr = manual_en_in && force_ref_lock_in;
	wire fd = manual_en_in && force_data_lock_in;
	//////////////////////////////////////////////////////////////////////
	AST_RESET_REF: assert property ($fell(rst_in) |-> !lk)
		else $error("lock flag set after reset");
	AST_PHASE: assert property (phase_det_en_out == lk)
		else $error("phase detector disagrees with state");
	AST_REF_SEL: assert property (ref_clk_out ==
		(pll_sel_in ? pll1_clk_in : pll0_clk_in))
		else $error("wrong reference clock");
	AST_AUTO_IN: assert property ($rose(lk) && au
		|-> $past(ppm_ok_in, 3))
		else $error("tracking without frequency window");
	AST_AUTO_OUT: assert property ((au && !ppm_ok_in)[*4] |=> !lk)
		else $error("no fallback on frequency loss");
	AST_PIPE_IN: assert property ($rose(lk) && au && pipe_mode_in
		|-> $past(signal_present_out))
		else $error("PIPE tracking without signal");
	AST_BYPASS: assert property (!enc_en_in |=> signal_present_out)
		else $error("signal present not bypassed");
	AST_FORCE_REF: assert property (fr[*3] |=> !lk)
		else $error("ref force ignored");
	AST_FORCE_DATA: assert property ((fd && !fr)[*3] |=> lk)
		else $error("data force ignored");
	AST_VLD_PULSE: assert property (word_vld_out |=> !word_vld_out)
		else $error("word strobe longer than one cycle");
endmodule

bind cdr_lock_ctrl_deserializer cdr_lock_checker chk (.*);

// file: testbench/lane_tx_model.sv
// Purpose: remote serial transmitter model
// Assumes: one bit per strobe in the mclk domain
// Notes:   idle line shows the inverse of the last bit
`timescale 1ns/1ps
module lane_tx_model (
	input  wire logic	mclk_in,     // Clock
	output logic		ser_bit_out, // Serial bit
	output logic		ser_vld_out  // Bit strobe
);
	initial begin
		ser_bit_out = 1'h0;
		ser_vld_out = 1'h0;
	end
	// Gap gives a slow sender; with gap 0, hold keeps strobe up for a next word
	task automatic send(input logic [9:0] w, input logic wide,
		input int gap, input logic hold);
		for (int i = 0; i < (wide ? 10 : 8); i++) begin
			ser_bit_out = w[i];
			ser_vld_out = 1'h1;
			@(posedge mclk_in);
			#1;
			if (gap > 0 || (i == (wide ? 9 : 7) && !hold)) begin
				ser_vld_out = 1'h0;
				ser_bit_out = ~ser_bit_out;
				repeat (gap) @(posedge mclk_in);
				#1;
			end
		end
	endtask
endmodule

// file: testbench/cdr_lock_ctrl_deserializer_test.sv
// Purpose: self-checking bench of the lock controller
// Assumes: 100 MHz mclk, inputs driven 1 ns after the edge
// Notes:   flag settles within six cycles of an input change
`timescale 1ns/1ps
module cdr_lock_ctrl_deserializer_test;
	logic		mclk_in, rst_in, manual_en_in, pipe_mode_in, enc_en_in;
	logic		level_above_in, ppm_ok_in, force_ref_lock_in, pll_sel_in;
	logic		force_data_lock_in, pll0_clk_in, pll1_clk_in, wide_in;
	logic		fast_clk_in, slow_clk_in, ser_bit_in, ser_vld_in;
	logic		signal_present_out, freq_lock_flag_out, phase_det_en_out;
	logic		ref_clk_out, deser_clk_out, pcs_clk_out, word_vld_out;
	logic [9:0]	word_out, got;
	logic [15:0]	cyc = 16'h0000;
	int		miscompares, num_checks, nwords;
	// Rows: manual, ref force, data force, window, expected flag
	logic [4:0]	rows [8] = '{5'h03, 5'h00, 5'h1E, 5'h15,
				     5'h13, 5'h10, 5'h1A, 5'h0B};
	cdr_lock_ctrl_deserializer uut (.*);
	lane_tx_model txm (.mclk_in(mclk_in), .ser_bit_out(ser_bit_in),
		.ser_vld_out(ser_vld_in));
	//////////////////////////////////////////////////////////////////////
	// Slow side clocks from a cycle count; also catches words, timeout
	assign {slow_clk_in, fast_clk_in, pll1_clk_in, pll0_clk_in} = cyc[3:0];
	always @(posedge mclk_in) begin
		cyc <= cyc + 16'h1;
		if (word_vld_out === 1'h1) begin
			got <= word_out;
			nwords <= nwords + 1;
		end
		if (cyc == 16'h0BB8) begin
			miscompares++;
			conclude();
		end
	end
	initial begin
		mclk_in = 1'h0;
		forever #5 mclk_in = ~mclk_in;
	end
	task automatic cycles(input int n);
		repeat (n) @(posedge mclk_in);
		#1;
	endtask
	task automatic check(input logic [9:0] a, input logic [9:0] e);
		num_checks++;
		if (a !== e) begin
			$display("ERROR t=%0t got=%h exp=%h", $time, a, e);
			miscompares++;
		end
	endtask
	// Width changes only under reset
	task automatic reset(input logic w);
		rst_in = 1'h1;
		wide_in = w;
		cycles(2);
		rst_in = 1'h0;
	endtask
	task automatic conclude();
		if (miscompares == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	//////////////////////////////////////////////////////////////////////
	initial begin
		{manual_en_in, pipe_mode_in, level_above_in, pll_sel_in} = 4'h0;
		{force_ref_lock_in, force_data_lock_in} = 2'h0;
		enc_en_in = 1'h1;
		ppm_ok_in = 1'h1;
		reset(1'h0);
		check(freq_lock_flag_out, 10'h0);
		foreach (rows[i]) begin
			{manual_en_in, force_ref_lock_in, force_data_lock_in,
				ppm_ok_in} = rows[i][4:1];
			pll_sel_in = i[0];
			cycles(6);
			check(freq_lock_flag_out, rows[i][0]);
			// Clock routing is pure wiring; any swap shows here
			check(deser_clk_out, fast_clk_in);
			check(pcs_clk_out, slow_clk_in);
			check(ref_clk_out, pll_sel_in ? pll1_clk_in : pll0_clk_in);
		end
		// PIPE: entry and fallback follow the detector
		{manual_en_in, pipe_mode_in, ppm_ok_in} = 3'h3;
		cycles(8);
		check(freq_lock_flag_out, 10'h0);
		level_above_in = 1'h1;
		cycles(8);
		check({signal_present_out, freq_lock_flag_out}, 10'h3);
		level_above_in = 1'h0;
		cycles(8);
		check({signal_present_out, freq_lock_flag_out}, 10'h0);
		pipe_mode_in = 1'h0;
		cycles(8);
		check(freq_lock_flag_out, 10'h1);
		enc_en_in = 1'h0;
		cycles(3);
		check(signal_present_out, 10'h1);
		// Bits in reference-locked state are dropped
		ppm_ok_in = 1'h0;
		cycles(6);
		txm.send(10'h0FF, 1'h0, 1, 1'h0);
		cycles(2);
		check(nwords[9:0], 10'h0);
		ppm_ok_in = 1'h1;
		cycles(6);
		txm.send(10'h0A5, 1'h0, 0, 1'h1);
		check(word_out, 10'h0A5);
		txm.send(10'h05A, 1'h0, 0, 1'h0);
		cycles(2);
		check(nwords[9:0], 10'h2);
		check(got, 10'h05A);
		// Mid-run reset must drop a held lock
		reset(1'h1);
		check(freq_lock_flag_out, 10'h0);
		cycles(6);
		txm.send(10'h2C7, 1'h1, 2, 1'h0);
		cycles(2);
		check(got, 10'h2C7);
		conclude();
	end
endmodule
